/* rwsc_reset_watchdog_sleep.sv */
// Reset sequencer, sleep timer, watchdog and sleep-state clock gating
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rwsc_params.svh"
module rwsc_reset_watchdog_sleep #(
  parameter int STARTUP_CYC = `RWSC_STARTUP_CYC,
  parameter int CAL_CYC = `RWSC_CAL_CYC,
  parameter int EXTERNAL_RESET_PIN_CYC = `RWSC_EXTERNAL_RESET_PIN_CYC,
  parameter int SLEEP_BITS = 15
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic external_reset_pin,
  input wire logic slow_tick,
  input wire logic irq_pending,
  input wire logic global_irq_enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic cpu_run,
  output logic cpu_in_reset,
  output logic calibrating,
  output logic main_clk_enable,
  output logic sleep_irq,
  output logic watchdog_reset_event,
  output logic analog_power,
  output logic [3:0] analog_block_enable,
  output logic crystal_selected,
  output logic low_speed_osc_enable
);
  // Refuse counts that the counters below cannot hold
  initial begin
    if (STARTUP_CYC < 1) begin
      $error("rwsc: STARTUP_CYC must be at least 1");
    end
    if (CAL_CYC < 1) begin
      $error("rwsc: CAL_CYC must be at least 1");
    end
    if (EXTERNAL_RESET_PIN_CYC < 1) begin
      $error("rwsc: EXTERNAL_RESET_PIN_CYC must be at least 1");
    end
    if (EXTERNAL_RESET_PIN_CYC > 65535) begin
      $error("rwsc: EXTERNAL_RESET_PIN_CYC exceeds the 16-bit pin counter");
    end
    // Longest period is 32768 ticks
    if (SLEEP_BITS < 15 || SLEEP_BITS > 24) begin
      $error("rwsc: SLEEP_BITS out of range");
    end
  end

  typedef struct packed {
    rwsc_pkg::rwsc_state_t state;
    logic [31:0] seq_cnt;
    logic [15:0] external_reset_pin_cnt;
    logic external_reset_pin_s1;
    logic external_reset_pin_s2;
    logic tick_s1;
    logic tick_s2;
    logic tick_d;
    logic [7:0] status;
    logic wdt_en;
    logic [1:0] wdt_cnt;
    logic [23:0] sleep_cnt;
    logic [1:0] sleep_sel;
    logic xtal_req;
    logic xtal_sel;
    logic pll_en;
    logic analog_pwr;
    logic [3:0] analog_en;
    logic full_sleep;
    logic half_done;
    logic sleep_irq;
    logic wdr_pulse;
    logic [7:0] rdata;
  } rwsc_state_s_t;

  rwsc_state_s_t s_reg;
  rwsc_state_s_t s_next;

  // Overflow period in slow ticks per selection
  function automatic logic [23:0] sleep_period(input logic [1:0] sel);
    case (sel)
      2'h0: sleep_period = 24'h000040;
      2'h1: sleep_period = 24'h000200;
      2'h2: sleep_period = 24'h001000;
      default: sleep_period = 24'h008000;
    endcase
  endfunction : sleep_period

  // Full-count and last-count compare values
  localparam logic [15:0] EXTERNAL_RESET_PIN_FULL = 16'(EXTERNAL_RESET_PIN_CYC);
  localparam logic [15:0] EXTERNAL_RESET_PIN_LAST = 16'(EXTERNAL_RESET_PIN_CYC - 1);
  localparam logic [31:0] STARTUP_LAST = 32'(STARTUP_CYC - 1);
  localparam logic [31:0] CAL_LAST = 32'(CAL_CYC - 1);
  localparam logic [1:0] WDT_LAST = `RWSC_WDT_LIMIT - 2'h1;

  // One-cycle strobe aimed at one register offset
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = strobe && (addr == target);
  endfunction : reg_hit

  // State image shared by power-on and external reset
  function automatic rwsc_state_s_t reset_image();
    reset_image = '0;
    reset_image.state = rwsc_pkg::RWSC_ST_STARTUP;
    reset_image.status = `RWSC_STATUS_RESET;
    reset_image.wdt_en = 1'b0;
    reset_image.analog_pwr = 1'b1;
  endfunction : reset_image

  // Edge of the synchronised slow clock
  function automatic logic slow_edge(input logic now, input logic was, input logic rising);
    if (rising) begin
      slow_edge = now && !was;
    end else begin
      slow_edge = !now && was;
    end
  endfunction : slow_edge

  function automatic logic in_state(input rwsc_pkg::rwsc_state_t cur,
                                    input rwsc_pkg::rwsc_state_t want);
    in_state = (cur == want);
  endfunction : in_state

  // Read-back word; unmapped and write-only offsets read zero
  function automatic logic [7:0] read_word(input logic [7:0] addr, input rwsc_state_s_t s,
                                           input logic ies);
    case (addr)
      `RWSC_ADDR_STATUS: begin
        read_word = s.status;
        read_word[`RWSC_BIT_IES] = ies;
      end
      `RWSC_ADDR_SLEEP_CFG: begin
        read_word = {4'h0, s.pll_en, s.xtal_req, s.sleep_sel};
      end
      `RWSC_ADDR_ANALOG: begin
        read_word = {3'h0, s.analog_pwr, s.analog_en};
      end
      `RWSC_ADDR_CLOCK_CFG: begin
        read_word = {s.wdt_en, s.wdt_cnt, s.full_sleep, s.xtal_sel, s.state};
      end
      default: begin
        read_word = 8'h00;
      end
    endcase
  endfunction : read_word

  logic tick_rise;
  logic tick_fall;
  logic overflow;
  logic por_seq;
  logic dog_fire;
  logic wr_status;
  logic wr_clear;
  logic wr_sleep_cfg;
  logic wr_analog;

  always_comb begin
    s_next = s_reg;
    tick_rise = slow_edge(s_reg.tick_s2, s_reg.tick_d, 1'b1);
    tick_fall = slow_edge(s_reg.tick_s2, s_reg.tick_d, 1'b0);
    wr_status = reg_hit(reg_wr, reg_addr, `RWSC_ADDR_STATUS);
    wr_clear = reg_hit(reg_wr, reg_addr, `RWSC_ADDR_WDT_CLEAR);
    wr_sleep_cfg = reg_hit(reg_wr, reg_addr, `RWSC_ADDR_SLEEP_CFG);
    wr_analog = reg_hit(reg_wr, reg_addr, `RWSC_ADDR_ANALOG);
    s_next.sleep_irq = 1'b0;
    s_next.wdr_pulse = 1'b0;
    // Read data stand for the one cycle after the strobe
    s_next.rdata = 8'h00;

    // Two-stage synchronisers for the pin and the slow clock
    s_next.external_reset_pin_s1 = external_reset_pin;
    s_next.external_reset_pin_s2 = s_reg.external_reset_pin_s1;
    s_next.tick_s1 = slow_tick;
    s_next.tick_s2 = s_reg.tick_s1;
    s_next.tick_d = s_reg.tick_s2;

    // Pin must stay high the full minimum width
    if (s_reg.external_reset_pin_s2) begin
      if (s_reg.external_reset_pin_cnt < EXTERNAL_RESET_PIN_FULL) begin
        s_next.external_reset_pin_cnt = s_reg.external_reset_pin_cnt + 16'h0001;
      end
    end else begin
      s_next.external_reset_pin_cnt = 16'h0000;
    end
    por_seq = s_reg.external_reset_pin_s2 && (s_reg.external_reset_pin_cnt == EXTERNAL_RESET_PIN_LAST);

    // Sleep timer on slow clock, runs in every state
    overflow = 1'b0;
    if (tick_rise) begin
      if (s_reg.sleep_cnt >= sleep_period(s_reg.sleep_sel) - 24'h000001) begin
        s_next.sleep_cnt = 24'h000000;
        overflow = 1'b1;
      end else begin
        s_next.sleep_cnt = s_reg.sleep_cnt + 24'h000001;
      end
    end

    // Overflow drives the interrupt, crystal swap and watchdog
    if (overflow) begin
      s_next.sleep_irq = 1'b1;
      if (s_reg.xtal_req) begin
        s_next.xtal_sel = 1'b1;
      end
      if (s_reg.wdt_en) begin
        s_next.wdt_cnt = s_reg.wdt_cnt + 2'h1;
      end
    end
    dog_fire = overflow && s_reg.wdt_en && (s_reg.wdt_cnt == WDT_LAST);

    // Watchdog clear register, write-only
    if (wr_clear) begin
      s_next.wdt_cnt = 2'h0;
      if (reg_wdata == `RWSC_SLEEP_CLEAR_CODE) begin
        s_next.sleep_cnt = 24'h000000;
      end
    end

    // Power-up and watchdog flags clear on a written zero; sleep and halt bits take the written value
    if (wr_status) begin
      if (!reg_wdata[`RWSC_BIT_POWERUP]) begin
        s_next.status[`RWSC_BIT_POWERUP] = 1'b0;
        s_next.wdt_en = 1'b1;
      end
      if (!reg_wdata[`RWSC_BIT_DOGRST]) begin
        s_next.status[`RWSC_BIT_DOGRST] = 1'b0;
      end
      s_next.status[`RWSC_BIT_SLEEP] = reg_wdata[`RWSC_BIT_SLEEP];
      s_next.status[`RWSC_BIT_HALT] = reg_wdata[`RWSC_BIT_HALT];
    end

    // Sleep period, crystal request and PLL flag
    if (wr_sleep_cfg) begin
      s_next.sleep_sel = reg_wdata[1:0];
      s_next.xtal_req = reg_wdata[2];
      s_next.pll_en = reg_wdata[3];
    end
    // Array power bit overrides the block enables
    if (wr_analog) begin
      s_next.analog_pwr = reg_wdata[4];
      s_next.analog_en = reg_wdata[3:0];
      s_next.full_sleep = 1'b0;
    end

    // Processor sequencer
    case (s_reg.state)
      rwsc_pkg::RWSC_ST_STARTUP: begin
        s_next.seq_cnt = s_reg.seq_cnt + 32'h1;
        if (s_reg.seq_cnt == STARTUP_LAST) begin
          s_next.seq_cnt = 32'h0;
          s_next.state = rwsc_pkg::RWSC_ST_CALIB;
        end
      end
      rwsc_pkg::RWSC_ST_CALIB: begin
        s_next.seq_cnt = s_reg.seq_cnt + 32'h1;
        if (s_reg.seq_cnt == CAL_LAST) begin
          s_next.seq_cnt = 32'h0;
          s_next.state = rwsc_pkg::RWSC_ST_RUN;
        end
      end
      rwsc_pkg::RWSC_ST_RUN: begin
        if (s_next.status[`RWSC_BIT_HALT]) begin
          s_next.state = rwsc_pkg::RWSC_ST_HALT;
        end else if (s_next.status[`RWSC_BIT_SLEEP]) begin
          s_next.state = rwsc_pkg::RWSC_ST_SLEEP;
          s_next.full_sleep = !s_reg.analog_pwr;
        end
      end
      rwsc_pkg::RWSC_ST_SLEEP: begin
        if (irq_pending && !s_reg.status[`RWSC_BIT_HALT]) begin
          s_next.state = rwsc_pkg::RWSC_ST_HOLDOFF;
          s_next.half_done = 1'b0;
        end
      end
      rwsc_pkg::RWSC_ST_HOLDOFF: begin
        // Full slow cycle with PLL, half cycle without
        if (tick_fall || tick_rise) begin
          s_next.half_done = 1'b1;
          if (!s_reg.pll_en || s_reg.half_done) begin
            s_next.state = rwsc_pkg::RWSC_ST_RUN;
            s_next.status[`RWSC_BIT_SLEEP] = 1'b0;
            s_next.full_sleep = 1'b0;
          end
        end
      end
      rwsc_pkg::RWSC_ST_HALT: begin
        // Only a reset or the watchdog leaves halt
        s_next.state = rwsc_pkg::RWSC_ST_HALT;
      end
      default: begin
        s_next.state = rwsc_pkg::RWSC_ST_STARTUP;
      end
    endcase

    // Watchdog restart keeps only its own flag
    if (dog_fire) begin
      s_next.state = rwsc_pkg::RWSC_ST_STARTUP;
      s_next.seq_cnt = 32'h0;
      s_next.status = 8'h00;
      s_next.status[`RWSC_BIT_DOGRST] = 1'b1;
      s_next.wdt_cnt = 2'h0;
      s_next.sleep_cnt = 24'h000000;
      s_next.sleep_sel = 2'h0;
      s_next.wdr_pulse = 1'b1;
    end

    // External reset takes the power-on path; synchronisers keep running
    if (por_seq) begin
      s_next = reset_image();
      s_next.status = `RWSC_STATUS_RESET;
      s_next.wdt_en = 1'b0;
      s_next.external_reset_pin_s1 = external_reset_pin;
      s_next.external_reset_pin_s2 = s_reg.external_reset_pin_s1;
      s_next.external_reset_pin_cnt = s_reg.external_reset_pin_cnt + 16'h0001;
      s_next.tick_s1 = slow_tick;
      s_next.tick_s2 = s_reg.tick_s1;
      s_next.tick_d = s_reg.tick_s2;
    end

    if (reg_rd) begin
      s_next.rdata = read_word(reg_addr, s_reg, global_irq_enable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= reset_image();
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs decoded from the registered state
  assign reg_rdata = s_reg.rdata;
  assign cpu_run = in_state(s_reg.state, rwsc_pkg::RWSC_ST_RUN);
  assign cpu_in_reset = in_state(s_reg.state, rwsc_pkg::RWSC_ST_STARTUP);
  assign calibrating = in_state(s_reg.state, rwsc_pkg::RWSC_ST_CALIB);
  assign main_clk_enable = !in_state(s_reg.state, rwsc_pkg::RWSC_ST_SLEEP);
  assign sleep_irq = s_reg.sleep_irq;
  assign watchdog_reset_event = s_reg.wdr_pulse;
  assign analog_power = s_reg.analog_pwr && !s_reg.full_sleep;
  assign analog_block_enable = analog_power ? s_reg.analog_en : 4'h0;
  assign crystal_selected = s_reg.xtal_sel;
  assign low_speed_osc_enable = !s_reg.xtal_sel;
endmodule : rwsc_reset_watchdog_sleep
`default_nettype wire

/* rwsc_params.svh */
// Offsets, field positions, reset values and timing counts of the reset/sleep controller
`ifndef RWSC_PARAMS_SVH
`define RWSC_PARAMS_SVH
`define RWSC_ADDR_WDT_CLEAR 8'he3
`define RWSC_ADDR_STATUS 8'hff
`define RWSC_ADDR_SLEEP_CFG 8'he0
`define RWSC_ADDR_ANALOG 8'he1
`define RWSC_ADDR_CLOCK_CFG 8'he2
`define RWSC_STATUS_RESET 8'h10
`define RWSC_BIT_HALT 0
`define RWSC_BIT_SLEEP 3
`define RWSC_BIT_POWERUP 4
`define RWSC_BIT_DOGRST 5
`define RWSC_BIT_IES 7
`define RWSC_SLEEP_CLEAR_CODE 8'h38
`define RWSC_WDT_LIMIT 2'h3
`define RWSC_CLK_HZ 200000000
`define RWSC_STARTUP_MS 64
`define RWSC_STARTUP_CYC ((`RWSC_STARTUP_MS * (`RWSC_CLK_HZ / 1000)))
`define RWSC_CAL_CPU_CYC 2502
`define RWSC_CAL_CPU_HZ 3000000
`define RWSC_CAL_CYC ((`RWSC_CAL_CPU_CYC * (`RWSC_CLK_HZ / 1000)) / (`RWSC_CAL_CPU_HZ / 1000))
`define RWSC_EXTERNAL_RESET_PIN_NS 10000
`define RWSC_EXTERNAL_RESET_PIN_CYC ((`RWSC_EXTERNAL_RESET_PIN_NS * (`RWSC_CLK_HZ / 1000000) + 999) / 1000)
`endif

/* rwsc_pkg.sv */
// Types of the reset/sleep controller
package rwsc_pkg;
  typedef enum logic [2:0] {
    RWSC_ST_STARTUP = 3'b000,
    RWSC_ST_CALIB = 3'b001,
    RWSC_ST_RUN = 3'b010,
    RWSC_ST_SLEEP = 3'b011,
    RWSC_ST_HOLDOFF = 3'b100,
    RWSC_ST_HALT = 3'b101
  } rwsc_state_t;
endpackage : rwsc_pkg

/* rwsc_far_model.sv */
// Far side model: slow oscillator and external reset pin driver
`timescale 1ns/1ps
`default_nettype none
module rwsc_far_model (
  input wire logic clk_sys,
  input wire logic pin_go,
  input wire logic [7:0] pin_len,
  output logic slow_tick,
  output logic external_reset_pin
);
  logic [3:0] div = 4'h0;
  logic [7:0] left = 8'h00;
  initial slow_tick = 1'b0;
  always @(posedge clk_sys) begin
    div <= div + 4'h1;
    if (div == 4'hf) slow_tick <= !slow_tick;
    if (pin_go) left <= pin_len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign external_reset_pin = (left != 8'h00);
endmodule : rwsc_far_model
`default_nettype wire

/* rwsc_checker_asserts.sv */
// Port-level checks of the reset/sleep controller
`timescale 1ns/1ps
`default_nettype none
module rwsc_checker_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cpu_run,
  input wire logic cpu_in_reset,
  input wire logic calibrating,
  input wire logic main_clk_enable,
  input wire logic sleep_irq,
  input wire logic watchdog_reset_event,
  input wire logic analog_power,
  input wire logic [3:0] analog_block_enable,
  input wire logic crystal_selected,
  input wire logic low_speed_osc_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  reset_starts_delay_a: assert property (disable iff (1'b0) sys_rst |=> cpu_in_reset && !cpu_run)
    else $error("reset did not enter start-up");
  delay_holds_cpu_a: assert property (cpu_in_reset |-> !calibrating && !cpu_run)
    else $error("cpu active during start-up");
  calib_follows_a: assert property ($fell(cpu_in_reset) |-> calibrating)
    else $error("no calibration after start-up");
  vector_follows_a: assert property ($fell(calibrating) |-> cpu_run || cpu_in_reset)
    else $error("no run after calibration");
  irq_pulse_a: assert property (sleep_irq |=> !sleep_irq)
    else $error("sleep irq longer than one cycle");
  dog_restarts_a: assert property (watchdog_reset_event |-> ##[0:2] cpu_in_reset)
    else $error("watchdog did not restart");
  dog_pulse_a: assert property (watchdog_reset_event |=> !watchdog_reset_event)
    else $error("watchdog event too long");
  sleep_gated_a: assert property (!main_clk_enable |-> !cpu_run && !calibrating)
    else $error("cpu runs with clocks gated");
  wake_holdoff_a: assert property ($rose(main_clk_enable) |-> !cpu_run)
    else $error("no hold-off on wake");
  analog_off_a: assert property (!analog_power |-> analog_block_enable == 4'h0)
    else $error("analog block on while unpowered");
  osc_swap_a: assert property (low_speed_osc_enable != crystal_selected)
    else $error("oscillator select mismatch");
endmodule : rwsc_checker_asserts
bind rwsc_reset_watchdog_sleep rwsc_checker_asserts rwsc_checker_asserts_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_run(cpu_run), .cpu_in_reset(cpu_in_reset),
  .calibrating(calibrating), .main_clk_enable(main_clk_enable), .sleep_irq(sleep_irq),
  .watchdog_reset_event(watchdog_reset_event), .analog_power(analog_power),
  .analog_block_enable(analog_block_enable), .crystal_selected(crystal_selected),
  .low_speed_osc_enable(low_speed_osc_enable));
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the reset/sleep controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t mismatch", $time); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_pending = 1'b0;
  logic global_irq_enable = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_go = 1'b0;
  logic [7:0] pin_len = 8'h00;
  logic slow_tick, external_reset_pin, cpu_run, cpu_in_reset, calibrating, main_clk_enable;
  logic sleep_irq, watchdog_reset_event, analog_power, crystal_selected, low_speed_osc_enable;
  logic [7:0] reg_rdata;
  logic [3:0] analog_block_enable;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int k;
  initial forever #2.5 clk_sys = ~clk_sys;
  rwsc_far_model rwsc_far_model_inst (.clk_sys(clk_sys), .pin_go(pin_go), .pin_len(pin_len),
    .slow_tick(slow_tick), .external_reset_pin(external_reset_pin));
  rwsc_reset_watchdog_sleep #(.STARTUP_CYC(50), .CAL_CYC(30), .EXTERNAL_RESET_PIN_CYC(4))
    rwsc_reset_watchdog_sleep_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .external_reset_pin(external_reset_pin), .slow_tick(slow_tick), .irq_pending(irq_pending),
    .global_irq_enable(global_irq_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_run(cpu_run),
    .cpu_in_reset(cpu_in_reset), .calibrating(calibrating), .main_clk_enable(main_clk_enable),
    .sleep_irq(sleep_irq), .watchdog_reset_event(watchdog_reset_event),
    .analog_power(analog_power), .analog_block_enable(analog_block_enable),
    .crystal_selected(crystal_selected), .low_speed_osc_enable(low_speed_osc_enable));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic wait_run();
    n = 0;
    while (cpu_run !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_run
  task automatic pulse(input logic [7:0] len);
    @(posedge clk_sys);
    pin_len <= len;
    pin_go <= 1'b1;
    @(posedge clk_sys);
    pin_go <= 1'b0;
    repeat (30) @(negedge clk_sys);
  endtask : pulse
  task automatic t_boot();
    @(negedge clk_sys);
    `CHK(cpu_in_reset, 1'b1)
    `CHK(low_speed_osc_enable, 1'b1)
    wait_run();
    `CHK(n >= 78 && n <= 86, 1'b1)
    rd(8'hff, 8'h10);
    rd(8'h00, 8'h00);
    wr(8'hff, 8'h30);
    rd(8'hff, 8'h10);
    $display("boot done");
  endtask : t_boot
  task automatic t_sleep();
    wr(8'he1, 8'h05);
    `CHK(analog_power, 1'b0)
    `CHK(analog_block_enable, 4'h0)
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    wr(8'hff, 8'h18);
    repeat (50) @(negedge clk_sys);
    `CHK(main_clk_enable, 1'b0)
    `CHK(cpu_run, 1'b0)
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    wait_run();
    `CHK(n >= 1 && n < 200, 1'b1)
    `CHK(analog_power, 1'b0)
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    rd(8'hff, 8'h90);
    wr(8'he1, 8'h15);
    `CHK(analog_block_enable, 4'h5)
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    $display("sleep done");
  endtask : t_sleep
  task automatic t_dog();
    wr(8'hff, 8'h00);
    rd(8'hff, 8'h00);
    wr(8'he3, 8'h38);
    n = 0;
    k = 0;
    while (watchdog_reset_event !== 1'b1 && k < 12000) begin
      @(negedge clk_sys);
      k++;
      if (sleep_irq === 1'b1) n++;
      if (sleep_irq === 1'b1 && n == 2) wr(8'he3, 8'h55);
    end
    `CHK(n, 5)
    repeat (3) @(negedge clk_sys);
    rd(8'hff, 8'h20);
    wait_run();
    wr(8'hff, 8'h00);
    rd(8'hff, 8'h00);
    $display("watchdog done");
  endtask : t_dog
  task automatic t_external_reset_pin();
    wr(8'he3, 8'h38);
    wr(8'hff, 8'h01);
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    repeat (50) @(negedge clk_sys);
    `CHK(cpu_run, 1'b0)
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    pulse(8'h02);
    `CHK(cpu_run, 1'b0)
    pulse(8'h08);
    wait_run();
    `CHK(n > 40, 1'b1)
    rd(8'hff, 8'h10);
    k = 0;
    repeat (8000) begin
      @(negedge clk_sys);
      if (watchdog_reset_event === 1'b1) k++;
    end
    `CHK(k, 0)
    $display("external reset done");
  endtask : t_external_reset_pin
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_boot();
    t_sleep();
    t_dog();
    t_external_reset_pin();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
